//--- rtl/msovl_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "msovl_consts.svh"
module msovl_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic [7:0] link_cmd,
  input wire logic [15:0] link_wdata,
  output logic link_busy_q,
  output logic [15:0] link_rdata_q,
  output logic link_rvalid_q,
  input wire logic meas_valid,
  input wire logic meas_is_cur,
  input wire logic [3:0] meas_chan,
  input wire logic [15:0] meas_adc,
  input wire logic [11:0] margin_fail,
  output logic margin_load_q,
  output logic [3:0] margin_chan_q,
  output msovl_pkg::msovl_op_t margin_sel_q,
  output logic [15:0] margin_target_q,
  output logic fault_resp_req_q,
  output logic [3:0] fault_resp_chan_q,
  output logic [7:0] fault_resp_action_q,
  output logic [11:0] ov_fault_act_q,
  output logic alert_n_q
);
  localparam int NCH = `MSOVL_NCH;

  function automatic logic [63:0] meas_term(input logic [15:0] adc);
    meas_term = 64'(adc) * `MSOVL_ADC_FS_MV * `MSOVL_SCALE_ONE;
  endfunction : meas_term
  function automatic logic [63:0] lim_term(input logic [15:0] lim, input logic [15:0] sc);
    lim_term = (64'(lim) * 64'(sc)) << `MSOVL_ADC_BITS;
  endfunction : lim_term
  function automatic logic [15:0] sat_div(input logic [63:0] num, input logic [63:0] den);
    logic [63:0] q;
    q = (den == 64'h0) ? 64'hFFFF : num / den;
    sat_div = (q > 64'hFFFF) ? 16'hFFFF : q[15:0];
  endfunction : sat_div

  msovl_link_if lk ();
  msovl_link_cdc u_cdc (
    .clk(clk),
    .rst(rst),
    .link_clk(link_clk),
    .link_rst(link_rst),
    .link_wr(link_wr),
    .link_rd(link_rd),
    .link_cmd(link_cmd),
    .link_wdata(link_wdata),
    .link_busy_q(link_busy_q),
    .link_rdata_q(link_rdata_q),
    .link_rvalid_q(link_rvalid_q),
    .core(lk.cdc)
  );

  logic [15:0] mh_q [NCH];
  logic [15:0] ml_q [NCH];
  logic [15:0] scale_q [NCH];
  logic [15:0] gain_q [NCH];
  logic [15:0] ovf_q [NCH];
  logic [15:0] ovw_q [NCH];
  logic [15:0] vout_q [NCH];
  logic [15:0] iout_q [NCH];
  logic [7:0] fresp_q [NCH];
  logic [7:0] sv_q [NCH];
  logic [7:0] mfr_q [NCH];
  msovl_pkg::msovl_op_t op_q [NCH];
  logic [NCH-1:0] ovw_act_q;
  logic [3:0] page_q;
  logic [7:0] mode_q;
  logic [3:0] last_ch_q;

  // host side decode
  wire logic pg_ok = page_q < NCH;
  wire logic [3:0] pg = pg_ok ? page_q : 4'h0;
  wire logic wr = lk.req & ~lk.is_rd;
  wire logic wr_pg = wr & pg_ok;
  wire logic wr_op = wr_pg & (lk.cmd == `MSOVL_CMD_OPER);
  wire logic wr_clear = wr & (lk.cmd == `MSOVL_CMD_CLEAR);
  wire msovl_pkg::msovl_op_t op_w = msovl_pkg::msovl_op_t'(lk.wdata[1:0]);

  // measurement side decode
  wire logic [3:0] mc = (meas_chan < NCH) ? meas_chan : 4'h0;
  wire logic mv = meas_valid & (meas_chan < NCH);
  wire logic mv_v = mv & ~meas_is_cur;
  wire logic [63:0] m_term = meas_term(meas_adc);
  wire logic [63:0] f_term = lim_term(ovf_q[mc], scale_q[mc]);
  wire logic [63:0] w_term = lim_term(ovw_q[mc], scale_q[mc]);
  wire logic [63:0] v_den = 64'(scale_q[mc]) << `MSOVL_ADC_BITS;
  wire logic [63:0] i_den = 64'(gain_q[mc]) << `MSOVL_ADC_BITS;
  wire logic [63:0] i_num = 64'(meas_adc) * `MSOVL_ADC_FS_MV * `MSOVL_CUR_SCALE;
  logic ovf_nxt, ovw_nxt;

  msovl_limit_chk u_ovf (
    .eval(mv_v),
    .meas(m_term),
    .lim(f_term),
    .prev(ov_fault_act_q[mc]),
    .nxt(ovf_nxt)
  );
  msovl_limit_chk u_ovw (
    .eval(mv_v),
    .meas(m_term),
    .lim(w_term),
    .prev(ovw_act_q[mc]),
    .nxt(ovw_nxt)
  );
  wire logic ovf_rise = mv_v & ovf_nxt & ~ov_fault_act_q[mc];

  // configuration words, one 16-bit word per command
  always_ff @(posedge clk) begin
    if (rst) begin
      page_q <= 4'h0;
      mode_q <= `MSOVL_RST_MODE;
      for (int i = 0; i < NCH; i++) begin
        mh_q[i] <= `MSOVL_RST_MARGIN;
        ml_q[i] <= `MSOVL_RST_MARGIN;
        scale_q[i] <= `MSOVL_RST_SCALE;
        gain_q[i] <= `MSOVL_RST_CALG;
        ovf_q[i] <= `MSOVL_RST_LIMIT;
        ovw_q[i] <= `MSOVL_RST_LIMIT;
        fresp_q[i] <= 8'h00;
      end
    end else if (wr) begin
      case (lk.cmd)
        `MSOVL_CMD_PAGE: page_q <= lk.wdata[3:0];
        `MSOVL_CMD_MODE: mode_q <= lk.wdata[7:0];
        default: ;
      endcase
      if (pg_ok) begin
        case (lk.cmd)
          `MSOVL_CMD_MHIGH: mh_q[pg] <= lk.wdata;
          `MSOVL_CMD_MLOW: ml_q[pg] <= lk.wdata;
          `MSOVL_CMD_SCALE: scale_q[pg] <= lk.wdata;
          `MSOVL_CMD_CALG: gain_q[pg] <= lk.wdata;
          `MSOVL_CMD_OVF: ovf_q[pg] <= lk.wdata;
          `MSOVL_CMD_OVW: ovw_q[pg] <= lk.wdata;
          `MSOVL_CMD_FRESP: fresp_q[pg] <= lk.wdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // the target only moves on an operation write, so target rewrites alone change nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      margin_load_q <= 1'b0;
      margin_chan_q <= 4'h0;
      margin_sel_q <= msovl_pkg::MSOVL_OP_NOM;
      margin_target_q <= `MSOVL_RST_MARGIN;
      for (int i = 0; i < NCH; i++) op_q[i] <= msovl_pkg::MSOVL_OP_NOM;
    end else begin
      margin_load_q <= wr_op;
      if (wr_op) begin
        op_q[pg] <= op_w;
        margin_chan_q <= pg;
        margin_sel_q <= op_w;
        case (op_w)
          msovl_pkg::MSOVL_OP_MHIGH: margin_target_q <= mh_q[pg];
          msovl_pkg::MSOVL_OP_MLOW: margin_target_q <= ml_q[pg];
          default: margin_target_q <= margin_target_q;
        endcase
      end
    end
  end

  // conversion results and limit state
  always_ff @(posedge clk) begin
    if (rst) begin
      ov_fault_act_q <= 12'h000;
      ovw_act_q <= 12'h000;
      last_ch_q <= 4'h0;
      fault_resp_req_q <= 1'b0;
      fault_resp_chan_q <= 4'h0;
      fault_resp_action_q <= 8'h00;
      for (int i = 0; i < NCH; i++) begin
        vout_q[i] <= 16'h0000;
        iout_q[i] <= 16'h0000;
      end
    end else begin
      fault_resp_req_q <= ovf_rise;
      if (mv) last_ch_q <= mc;
      if (ovf_rise) begin
        fault_resp_chan_q <= mc;
        fault_resp_action_q <= fresp_q[mc];
      end
      if (mv_v) begin
        ov_fault_act_q[mc] <= ovf_nxt;
        ovw_act_q[mc] <= ovw_nxt;
        vout_q[mc] <= sat_div(m_term, v_den);
      end
      if (mv & meas_is_cur) iout_q[mc] <= sat_div(i_num, i_den);
    end
  end

  // latched status: a margin failure still present re-sets its bit each cycle, an active voltage limit on its channel's next reading; set beats clear
  logic [7:0] sv_d [NCH];
  logic [7:0] mfr_d [NCH];
  logic any_stat;
  always_comb begin
    any_stat = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      sv_d[i] = wr_clear ? 8'h00 : sv_q[i];
      mfr_d[i] = wr_clear ? 8'h00 : mfr_q[i];
      if (mv_v && mc == 4'(i)) begin
        sv_d[i][`MSOVL_SV_OVF] = sv_d[i][`MSOVL_SV_OVF] | ovf_nxt;
        sv_d[i][`MSOVL_SV_OVW] = sv_d[i][`MSOVL_SV_OVW] | ovw_nxt;
      end
      // a failed margin on a channel not at nominal latches its margin status bit
      if (margin_fail[i] && op_q[i] != msovl_pkg::MSOVL_OP_NOM) begin
        mfr_d[i][`MSOVL_MFR_MARGIN] = 1'b1;
      end
      any_stat = any_stat | (|sv_q[i]) | (|mfr_q[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alert_n_q <= 1'b1;
      for (int i = 0; i < NCH; i++) begin
        sv_q[i] <= 8'h00;
        mfr_q[i] <= 8'h00;
      end
    end else begin
      alert_n_q <= ~(mode_q[`MSOVL_MODE_ALERT_EN] & any_stat);
      for (int i = 0; i < NCH; i++) begin
        sv_q[i] <= sv_d[i];
        mfr_q[i] <= mfr_d[i];
      end
    end
  end

  function automatic logic [15:0] status_word(input logic [7:0] sv, input logic [7:0] mf);
    status_word = 16'h0000;
    status_word[`MSOVL_SW_VOUT] = |sv;
    status_word[`MSOVL_SW_VOUT_OV] = sv[`MSOVL_SV_OVF];
    status_word[`MSOVL_SW_MARGIN] = mf[`MSOVL_MFR_MARGIN];
  endfunction : status_word

  always_comb begin
    case (lk.cmd)
      `MSOVL_CMD_PAGE: lk.rdata = {12'h000, page_q};
      `MSOVL_CMD_OPER: lk.rdata = {14'h0, op_q[pg]};
      `MSOVL_CMD_MODE: lk.rdata = {8'h00, mode_q};
      `MSOVL_CMD_MHIGH: lk.rdata = mh_q[pg];
      `MSOVL_CMD_MLOW: lk.rdata = ml_q[pg];
      `MSOVL_CMD_SCALE: lk.rdata = scale_q[pg];
      `MSOVL_CMD_CALG: lk.rdata = gain_q[pg];
      `MSOVL_CMD_OVF: lk.rdata = ovf_q[pg];
      `MSOVL_CMD_OVW: lk.rdata = ovw_q[pg];
      `MSOVL_CMD_FRESP: lk.rdata = {8'h00, fresp_q[pg]};
      `MSOVL_CMD_STWORD: lk.rdata = status_word(sv_q[pg], mfr_q[pg]);
      `MSOVL_CMD_STVOUT: lk.rdata = {8'h00, sv_q[pg]};
      `MSOVL_CMD_STMFR: lk.rdata = {8'h00, mfr_q[pg]};
      `MSOVL_CMD_RDVOUT: lk.rdata = vout_q[pg];
      `MSOVL_CMD_RDIOUT: lk.rdata = iout_q[pg];
      default: lk.rdata = 16'hFFFF;
    endcase
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wr_mh = wr_pg & (lk.cmd == `MSOVL_CMD_MHIGH);
  wire logic wr_ml = wr_pg & (lk.cmd == `MSOVL_CMD_MLOW);
  wire logic [15:0] sw_margin_bit = 16'h0001 << `MSOVL_SW_MARGIN;
  sequence s_op_high;
    wr_op && op_w == msovl_pkg::MSOVL_OP_MHIGH;
  endsequence
  sequence s_ovf_trip;
    mv_v && ovf_nxt && !wr_clear;
  endsequence
  a_mh_apply: assert property (s_op_high |=> margin_load_q
    && margin_sel_q == msovl_pkg::MSOVL_OP_MHIGH && margin_target_q == $past(mh_q[pg])
    ##1 !margin_load_q) else $error("margin high not applied");
  a_mh_rewrite_quiet: assert property (wr_mh && !wr_op |=> $stable(margin_target_q))
    else $error("margin high rewrite moved output");
  a_ml_rewrite_quiet: assert property (wr_ml && !wr_op |=> $stable(margin_target_q))
    else $error("margin low rewrite moved output");
  a_margin_flag: assert property (margin_fail[pg]
    && op_q[pg] != msovl_pkg::MSOVL_OP_NOM |=> mfr_q[$past(pg)][`MSOVL_MFR_MARGIN]
    && (status_word(sv_q[$past(pg)], mfr_q[$past(pg)]) & sw_margin_bit) != 16'h0000)
    else $error("margin failure not flagged");
  a_ovf_latch: assert property (s_ovf_trip |=> sv_q[last_ch_q][`MSOVL_SV_OVF]
    && fault_resp_req_q == $past(ovf_rise)) else $error("ov fault not latched");
  a_ovf_hold: assert property (mv_v && ov_fault_act_q[mc]
    && (m_term * `MSOVL_HYST_DEN) > (f_term * `MSOVL_HYST_NUM) |=> ov_fault_act_q[last_ch_q])
    else $error("ov fault cleared above hysteresis");
  a_ovw_no_resp: assert property (mv_v && ovw_nxt && !ovf_rise && !wr_clear
    |=> sv_q[last_ch_q][`MSOVL_SV_OVW] && !fault_resp_req_q) else $error("ov warning wrong");
  a_ovw_hold: assert property (mv_v && ovw_act_q[mc]
    && (m_term * `MSOVL_HYST_DEN) > (w_term * `MSOVL_HYST_NUM) |=> ovw_act_q[last_ch_q])
    else $error("ov warning cleared above hysteresis");
  a_alert_gate: assert property (!mode_q[`MSOVL_MODE_ALERT_EN] |=> alert_n_q)
    else $error("alert while disabled");
endmodule : msovl_top
`default_nettype wire

//--- rtl/msovl_consts.svh
`ifndef MSOVL_CONSTS_SVH
`define MSOVL_CONSTS_SVH
`define MSOVL_NCH 4'hC
`define MSOVL_CMD_PAGE 8'h00
`define MSOVL_CMD_OPER 8'h01
`define MSOVL_CMD_CLEAR 8'h03
`define MSOVL_CMD_MHIGH 8'h25
`define MSOVL_CMD_MLOW 8'h26
`define MSOVL_CMD_SCALE 8'h2A
`define MSOVL_CMD_CALG 8'h38
`define MSOVL_CMD_OVF 8'h40
`define MSOVL_CMD_OVW 8'h42
`define MSOVL_CMD_STWORD 8'h79
`define MSOVL_CMD_STVOUT 8'h7A
`define MSOVL_CMD_STMFR 8'h80
`define MSOVL_CMD_RDVOUT 8'h8B
`define MSOVL_CMD_RDIOUT 8'h8C
`define MSOVL_CMD_MODE 8'hD1
`define MSOVL_CMD_FRESP 8'hD5
// adc full scale in millivolts (2048) and unity scale (32767)
`define MSOVL_ADC_FS_MV 64'h800
`define MSOVL_SCALE_ONE 64'h7FFF
`define MSOVL_ADC_BITS 64'h10
// current readout in milliamps: 0.1 milliohm gain steps give factor 10000
`define MSOVL_CUR_SCALE 64'h2710
// clear threshold is 98% of the limit, kept as 49/50
`define MSOVL_HYST_NUM 64'h31
`define MSOVL_HYST_DEN 64'h32
`define MSOVL_SW_VOUT 4'hF
`define MSOVL_SW_VOUT_OV 4'h5
`define MSOVL_SW_MARGIN 4'h3
`define MSOVL_SV_OVF 3'h7
`define MSOVL_SV_OVW 3'h6
`define MSOVL_MFR_MARGIN 3'h0
`define MSOVL_MODE_ALERT_EN 3'h0
`define MSOVL_RST_SCALE 16'h7FFF
`define MSOVL_RST_CALG 16'h1388
`define MSOVL_RST_LIMIT 16'hFFFF
`define MSOVL_RST_MARGIN 16'h0000
`define MSOVL_RST_MODE 8'h01
`endif

//--- rtl/msovl_pkg.sv
package msovl_pkg;
  typedef enum logic [1:0] {MSOVL_OP_NOM, MSOVL_OP_MLOW, MSOVL_OP_MHIGH, MSOVL_OP_RSVD} msovl_op_t;
  typedef logic [15:0] msovl_word_t;
endpackage : msovl_pkg

//--- rtl/msovl_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface msovl_link_if;
  logic req;
  logic is_rd;
  logic [7:0] cmd;
  msovl_pkg::msovl_word_t wdata;
  msovl_pkg::msovl_word_t rdata;
  modport cdc (output req, output is_rd, output cmd, output wdata, input rdata);
  modport core (input req, input is_rd, input cmd, input wdata, output rdata);
endinterface : msovl_link_if
`default_nettype wire

//--- rtl/msovl_link_cdc.sv
`timescale 1ns/100ps
`default_nettype none
module msovl_link_cdc (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic [7:0] link_cmd,
  input wire logic [15:0] link_wdata,
  output logic link_busy_q,
  output logic [15:0] link_rdata_q,
  output logic link_rvalid_q,
  msovl_link_if.cdc core
);
  // link side: request words held stable while busy, so the core may read them directly
  logic req_tgl_q, rd_q, ack_s1_q, ack_s2_q, ack_s3_q;
  logic req_s1_q, req_s2_q, req_s3_q, ack_tgl_q;
  logic [15:0] rdata_hold_q;
  logic [7:0] cmd_q;
  logic [15:0] wdata_q;
  wire logic take = (link_wr | link_rd) & ~link_busy_q;
  wire logic ack_edge = ack_s2_q ^ ack_s3_q;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_tgl_q <= 1'b0;
      rd_q <= 1'b0;
      cmd_q <= 8'h00;
      wdata_q <= 16'h0000;
      link_busy_q <= 1'b0;
      link_rdata_q <= 16'h0000;
      link_rvalid_q <= 1'b0;
      {ack_s1_q, ack_s2_q, ack_s3_q} <= 3'h0;
    end else begin
      {ack_s1_q, ack_s2_q, ack_s3_q} <= {ack_tgl_q, ack_s1_q, ack_s2_q};
      link_rvalid_q <= ack_edge & rd_q;
      if (take) begin
        req_tgl_q <= ~req_tgl_q;
        rd_q <= link_rd;
        cmd_q <= link_cmd;
        wdata_q <= link_wdata;
        link_busy_q <= 1'b1;
      end else if (ack_edge) begin
        link_busy_q <= 1'b0;
        link_rdata_q <= rdata_hold_q;
      end
    end
  end
  // core side
  assign core.req = req_s2_q ^ req_s3_q;
  assign core.is_rd = rd_q;
  assign core.cmd = cmd_q;
  assign core.wdata = wdata_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      {req_s1_q, req_s2_q, req_s3_q} <= 3'h0;
      ack_tgl_q <= 1'b0;
      rdata_hold_q <= 16'h0000;
    end else begin
      {req_s1_q, req_s2_q, req_s3_q} <= {req_tgl_q, req_s1_q, req_s2_q};
      if (core.req) begin
        ack_tgl_q <= ~ack_tgl_q;
        rdata_hold_q <= core.rdata;
      end
    end
  end
  a_link_busy_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    take |=> link_busy_q && cmd_q == $past(link_cmd) && wdata_q == $past(link_wdata))
    else $error("link request not captured");
  // the core reads the request words directly, so they must not move while busy
  a_link_word_hold: assert property (@(posedge link_clk) disable iff (link_rst)
    link_busy_q |=> $stable(cmd_q) && $stable(wdata_q) && $stable(rd_q))
    else $error("link request moved while busy");
endmodule : msovl_link_cdc
`default_nettype wire

//--- rtl/msovl_limit_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "msovl_consts.svh"
module msovl_limit_chk (
  input wire logic eval,
  input wire logic [63:0] meas,
  input wire logic [63:0] lim,
  input wire logic prev,
  output logic nxt
);
  wire logic over = meas > lim;
  wire logic below = (meas * `MSOVL_HYST_DEN) <= (lim * `MSOVL_HYST_NUM);
  // once active, only a reading at or under 98% of the limit releases it
  assign nxt = eval ? (over | (prev & ~below)) : prev;
endmodule : msovl_limit_chk
`default_nettype wire

//--- verif/msovl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module msovl_host_model (
  input wire logic link_clk,
  input wire logic link_busy_q,
  input wire logic [15:0] link_rdata_q,
  input wire logic link_rvalid_q,
  output logic link_wr,
  output logic link_rd,
  output logic [7:0] link_cmd,
  output logic [15:0] link_wdata
);
  initial begin
    link_wr = 1'b0;
    link_rd = 1'b0;
    link_cmd = 8'h00;
    link_wdata = 16'h0000;
  end

  // one whole 16-bit word per request; held until the edge that takes it
  task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [15:0] wd,
      output logic [15:0] rdat, output logic rv);
    int n;
    n = 0;
    link_wr <= !rd;
    link_rd <= rd;
    link_cmd <= cmd;
    link_wdata <= wd;
    @(posedge link_clk);
    while (link_busy_q && n < 20) begin
      @(posedge link_clk);
      n++;
    end
    link_wr <= 1'b0;
    link_rd <= 1'b0;
    // a bounded wait: a hung link shows up as a wrong read value
    n = 0;
    do begin
      @(posedge link_clk);
      n++;
    end while (link_busy_q && n < 20);
    rdat = link_rdata_q;
    rv = link_rvalid_q;
  endtask : xfer
endmodule : msovl_host_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "msovl_consts.svh"
module tb_top;
  logic clk, rst, link_clk, link_rst, link_wr, link_rd, link_busy_q, link_rvalid_q;
  logic [7:0] link_cmd, fault_resp_action_q;
  logic [15:0] link_wdata, link_rdata_q, meas_adc, margin_target_q;
  logic meas_valid, meas_is_cur, margin_load_q, fault_resp_req_q, alert_n_q;
  logic [3:0] meas_chan, margin_chan_q, fault_resp_chan_q;
  logic [11:0] margin_fail, ov_fault_act_q;
  msovl_pkg::msovl_op_t margin_sel_q;
  int num_errors = 0;
  int checks = 0;
  int loads = 0;
  int resps = 0;
  int cycles = 0;

  msovl_top msovl_top_i (.clk, .rst, .link_clk, .link_rst, .link_wr, .link_rd,
    .link_cmd, .link_wdata, .link_busy_q, .link_rdata_q, .link_rvalid_q,
    .meas_valid, .meas_is_cur, .meas_chan, .meas_adc, .margin_fail, .margin_load_q,
    .margin_chan_q, .margin_sel_q, .margin_target_q, .fault_resp_req_q,
    .fault_resp_chan_q, .fault_resp_action_q, .ov_fault_act_q, .alert_n_q);
  msovl_host_model msovl_host_model_i (.link_clk, .link_busy_q, .link_rdata_q, .link_rvalid_q,
    .link_wr, .link_rd, .link_cmd, .link_wdata);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (margin_load_q === 1'b1) begin
      loads <= loads + 1;
    end
    if (fault_resp_req_q === 1'b1) begin
      resps <= resps + 1;
    end
    if (cycles == 60000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic v;
    msovl_host_model_i.xfer(1'b0, c, d, r, v);
  endtask : wr

  task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
    logic [15:0] r;
    logic v;
    msovl_host_model_i.xfer(1'b1, c, 16'h0000, r, v);
    chk(r, exp);
    chk({15'h0, v}, 16'h0001);
  endtask : rdc

  task automatic meas(input logic cur, input logic [3:0] ch, input logic [15:0] adc);
    @(posedge clk);
    meas_valid <= 1'b1;
    meas_is_cur <= cur;
    meas_chan <= ch;
    meas_adc <= adc;
    @(posedge clk);
    meas_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : meas

  task automatic t_reset_values;
    rdc(`MSOVL_CMD_SCALE, 16'h7FFF);
    rdc(`MSOVL_CMD_CALG, 16'h1388);
    rdc(`MSOVL_CMD_OVF, 16'hFFFF);
    rdc(`MSOVL_CMD_OVW, 16'hFFFF);
    rdc(`MSOVL_CMD_MHIGH, 16'h0000);
    rdc(8'h99, 16'hFFFF);
  endtask : t_reset_values

  task automatic t_margin;
    int n;
    // a page beyond the last channel refuses per-channel writes
    wr(`MSOVL_CMD_PAGE, 16'h000C);
    wr(`MSOVL_CMD_MHIGH, 16'h5555);
    wr(`MSOVL_CMD_PAGE, 16'h0000);
    rdc(`MSOVL_CMD_MHIGH, 16'h0000);
    wr(`MSOVL_CMD_PAGE, 16'h0002);
    wr(`MSOVL_CMD_MHIGH, 16'h1234);
    wr(`MSOVL_CMD_MLOW, 16'h0800);
    rdc(`MSOVL_CMD_MHIGH, 16'h1234);
    n = loads;
    wr(`MSOVL_CMD_OPER, 16'h0002);
    chk(16'(loads - n), 16'h0001);
    chk(16'(margin_sel_q), 16'h0002);
    chk({12'h000, margin_chan_q}, 16'h0002);
    chk(margin_target_q, 16'h1234);
    wr(`MSOVL_CMD_MHIGH, 16'h1300);
    chk(margin_target_q, 16'h1234);
    wr(`MSOVL_CMD_OPER, 16'h0002);
    chk(margin_target_q, 16'h1300);
    wr(`MSOVL_CMD_OPER, 16'h0001);
    wr(`MSOVL_CMD_MLOW, 16'h0700);
    chk(margin_target_q, 16'h0800);
    wr(`MSOVL_CMD_OPER, 16'h0001);
    chk(margin_target_q, 16'h0700);
    // nominal keeps the last target; margin low is then requested again
    wr(`MSOVL_CMD_OPER, 16'h0000);
    chk(16'(margin_sel_q), 16'h0000);
    chk(margin_target_q, 16'h0700);
    wr(`MSOVL_CMD_OPER, 16'h0001);
    chk(16'(margin_sel_q), 16'h0001);
  endtask : t_margin

  task automatic t_margin_fail;
    // channel 2 is margining low, channel 5 stays nominal
    @(posedge clk);
    margin_fail <= 12'h024;
    repeat (4) @(posedge clk);
    chk({15'h0, alert_n_q}, 16'h0000);
    margin_fail <= 12'h000;
    rdc(`MSOVL_CMD_STMFR, 16'h0001);
    rdc(`MSOVL_CMD_STWORD, 16'h0008);
    wr(`MSOVL_CMD_PAGE, 16'h0005);
    rdc(`MSOVL_CMD_STMFR, 16'h0000);
    wr(`MSOVL_CMD_CLEAR, 16'h0000);
    chk({15'h0, alert_n_q}, 16'h0001);
  endtask : t_margin_fail

  task automatic t_overvolt;
    int n;
    wr(`MSOVL_CMD_PAGE, 16'h0003);
    wr(`MSOVL_CMD_FRESP, 16'h005A);
    // warning kept below fault; unity scale gives adc/32 millivolts
    wr(`MSOVL_CMD_OVF, 16'h03E8);
    wr(`MSOVL_CMD_OVW, 16'h0384);
    n = resps;
    meas(1'b0, 4'h3, 16'h7D01);
    chk({4'h0, ov_fault_act_q}, 16'h0008);
    chk(16'(resps - n), 16'h0001);
    chk({8'h00, fault_resp_action_q}, 16'h005A);
    chk({12'h000, fault_resp_chan_q}, 16'h0003);
    rdc(`MSOVL_CMD_STVOUT, 16'h00C0);
    rdc(`MSOVL_CMD_STWORD, 16'h8020);
    meas(1'b0, 4'hC, 16'h0000);
    meas(1'b0, 4'h3, 16'h7A81);
    chk({4'h0, ov_fault_act_q}, 16'h0008);
    meas(1'b0, 4'h3, 16'h7A80);
    chk({4'h0, ov_fault_act_q}, 16'h0000);
    wr(`MSOVL_CMD_CLEAR, 16'h0000);
    meas(1'b0, 4'h3, 16'h6E41);
    rdc(`MSOVL_CMD_STVOUT, 16'h0040);
    rdc(`MSOVL_CMD_STWORD, 16'h8000);
    wr(`MSOVL_CMD_MODE, 16'h0000);
    chk({15'h0, alert_n_q}, 16'h0001);
    wr(`MSOVL_CMD_MODE, 16'h0001);
    chk({15'h0, alert_n_q}, 16'h0000);
    meas(1'b0, 4'h3, 16'h6E40);
    wr(`MSOVL_CMD_CLEAR, 16'h0000);
    rdc(`MSOVL_CMD_STVOUT, 16'h0000);
    meas(1'b0, 4'h3, 16'h7081);
    rdc(`MSOVL_CMD_STVOUT, 16'h0040);
    chk(16'(resps - n), 16'h0001);
    meas(1'b0, 4'h3, 16'h0000);
    wr(`MSOVL_CMD_CLEAR, 16'h0000);
  endtask : t_overvolt

  task automatic t_readings;
    wr(`MSOVL_CMD_PAGE, 16'h0004);
    meas(1'b0, 4'h4, 16'h8000);
    rdc(`MSOVL_CMD_RDVOUT, 16'h0400);
    // scale held for a 1.8 V nominal input keeps margining headroom
    wr(`MSOVL_CMD_SCALE, 16'h3FFF);
    meas(1'b0, 4'h4, 16'h8000);
    rdc(`MSOVL_CMD_RDVOUT, 16'h0800);
    meas(1'b1, 4'h4, 16'h8000);
    rdc(`MSOVL_CMD_RDIOUT, 16'h0800);
  endtask : t_readings

  initial begin
    rst = 1'b1;
    link_rst = 1'b1;
    meas_valid = 1'b0;
    meas_is_cur = 1'b0;
    meas_chan = 4'h0;
    meas_adc = 16'h0000;
    margin_fail = 12'h000;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge link_clk);
    link_rst <= 1'b0;
    @(posedge link_clk);
    t_reset_values();
    t_margin();
    t_margin_fail();
    t_overvolt();
    t_readings();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
